// [common/uart_host_pkg.sv]
// constants and types shared by the uart host bus controller
package uart_host_pkg;

   // register address map of the device outside
   localparam logic [2:0] MODEM_CTRL_ADDR = 3'h4;
   localparam int IRQ_OE_BIT = 3;
   localparam int IR_MODE_BIT = 6;
   localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;

   // bus style strap levels
   localparam logic STYLE_SEPARATE = 1'b1;
   localparam logic STYLE_DIRECTION = 1'b0;

   // direction line levels in direction-line style
   localparam logic DIR_READ = 1'b1;
   localparam logic DIR_WRITE = 1'b0;

   // bus phase timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETUP_NS = 50;
   localparam int STROBE_NS = 100;
   localparam int HOLD_NS = 50;
   localparam int PHASE_CNT_W = 4;

   // least times round up, and never below one cycle
   localparam int SETUP_CYC_RAW = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC_RAW = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC_RAW = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
   localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
   localparam int HOLD_CYC = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
   localparam logic [PHASE_CNT_W-1:0] SETUP_LOAD = PHASE_CNT_W'(SETUP_CYC - 1);
   localparam logic [PHASE_CNT_W-1:0] STROBE_LOAD = PHASE_CNT_W'(STROBE_CYC - 1);
   localparam logic [PHASE_CNT_W-1:0] HOLD_LOAD = PHASE_CNT_W'(HOLD_CYC - 1);

   // transaction sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SETUP = 5'h02,
      ST_STROBE = 5'h04,
      ST_HOLD = 5'h08,
      ST_DONE = 5'h10
   } host_state_t;

endpackage : uart_host_pkg

// [common/phase_timer_if.sv]
// interface between the sequencer and its phase timer
`timescale 1ns/1ps
`default_nettype none
interface phase_timer_if
   import uart_host_pkg::*;
   ();
   logic load;
   logic [PHASE_CNT_W-1:0] load_val;
   logic expired;

   modport ctrl (output load, output load_val, input expired);
   modport timer (input load, input load_val, output expired);
endinterface : phase_timer_if
`default_nettype wire

// [design/bus_phase_timer.sv]
// down counter that times each bus phase
`timescale 1ns/1ps
`default_nettype none
module bus_phase_timer
   import uart_host_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   phase_timer_if.timer tmr
);

   logic [PHASE_CNT_W-1:0] cnt_r;

   // load starts a phase; the count then runs down to zero and rests there
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= '0;
      end else if (tmr.load) begin
         cnt_r <= tmr.load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // expired looks at the count alone: the sequencer derives load from expired,
   // so feeding load back here would close a combinational loop
   assign tmr.expired = (cnt_r == '0);

endmodule : bus_phase_timer
`default_nettype wire

// [design/uart_host_bus_port.sv]
// host controller driving the parallel register port of a uart
// Summary of operation
// - host drives 3-bit register address per transaction
// - host drives data bus only for writes
// - chip select low frames every access
// - read strobe low, byte captured at rise
// - write data held across write strobe rise
// - direction line high reads, low writes
// - remote receive idle level follows mode
`timescale 1ns/1ps
`default_nettype none
module uart_host_bus_port
   import uart_host_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_bus_style,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [2:0] i_cmd_addr,
   input wire logic [7:0] i_cmd_wdata,
   output logic o_cmd_ready,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_rdata,
   output logic [2:0] o_reg_addr,
   output logic o_chip_select_n,
   output logic o_read_strobe_n,
   output logic o_write_strobe_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe,
   input wire logic i_irq,
   output logic o_irq_pending,
   output logic o_infrared_mode
);

   phase_timer_if tmr_if ();

   host_state_t state_r;
   host_state_t state_nxt;
   logic style_r;
   logic captured_r;
   logic write_r;
   logic [2:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] modem_control_reg_r;
   logic take;
   logic eff_write;
   logic [2:0] eff_addr;
   logic [7:0] eff_wdata;
   logic active_nxt;

   bus_phase_timer u_timer (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .tmr(tmr_if.timer)
   );

   // the strap is caught by a clocked process after release, not by the reset
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         style_r <= STYLE_SEPARATE;
         captured_r <= 1'b0;
      end else if (!captured_r) begin
         style_r <= i_bus_style;
         captured_r <= 1'b1;
      end
   end

   // a command is taken only while idle and ready
   assign take = i_cmd_valid && o_cmd_ready && (state_r == ST_IDLE);
   assign eff_write = take ? i_cmd_write : write_r;
   assign eff_addr = take ? i_cmd_addr : addr_r;
   assign eff_wdata = take ? i_cmd_wdata : wdata_r;

   // latched command stays put for the whole transaction
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         write_r <= 1'b0;
         addr_r <= 3'h0;
         wdata_r <= 8'h00;
      end else if (take) begin
         write_r <= i_cmd_write;
         addr_r <= i_cmd_addr;
         wdata_r <= i_cmd_wdata;
      end
   end

   // sequencer: setup, strobe, hold, then one done cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               state_nxt = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (tmr_if.expired) begin
               state_nxt = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (tmr_if.expired) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (tmr_if.expired) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // phase timer is loaded on every entry into a timed phase
   always_comb begin
      tmr_if.load = (state_nxt != state_r) &&
                    (state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_HOLD);
      case (state_nxt)
         ST_SETUP: tmr_if.load_val = SETUP_LOAD;
         ST_STROBE: tmr_if.load_val = STROBE_LOAD;
         ST_HOLD: tmr_if.load_val = HOLD_LOAD;
         default: tmr_if.load_val = '0;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign active_nxt = (state_nxt == ST_SETUP) || (state_nxt == ST_STROBE) ||
                       (state_nxt == ST_HOLD);

   // pins are registered from the next state so that every output is a flop
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_chip_select_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_reg_addr <= 3'h0;
      end else begin
         o_reg_addr <= eff_addr;
         if (style_r == STYLE_SEPARATE) begin
            o_chip_select_n <= !active_nxt;
            o_read_strobe_n <= !(state_nxt == ST_STROBE && !eff_write);
            o_write_strobe_n <= !(state_nxt == ST_STROBE && eff_write);
         end else begin
            // select only in the middle phase, so direction settles before and after
            o_chip_select_n <= !(state_nxt == ST_STROBE);
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= (active_nxt && eff_write) ? DIR_WRITE : DIR_READ;
         end
      end
   end

   // write data is driven from setup to hold, so it brackets the strobe
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
      end else begin
         o_data <= eff_wdata;
         o_data_oe <= active_nxt && eff_write;
      end
   end

   // read byte is sampled in the last strobe cycle, i.e. at the strobe's rise
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rsp_rdata <= 8'h00;
      end else if (state_r == ST_STROBE && state_nxt == ST_HOLD && !write_r) begin
         o_rsp_rdata <= i_data;
      end
   end

   // handshake flags toward the user side
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cmd_ready <= 1'b0;
         o_rsp_valid <= 1'b0;
      end else begin
         o_cmd_ready <= captured_r && (state_nxt == ST_IDLE);
         o_rsp_valid <= (state_nxt == ST_DONE);
      end
   end

   // shadow of the modem control byte, since the host cannot see the line float
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         modem_control_reg_r <= MODEM_CTRL_RESET;
      end else if (state_r == ST_DONE && write_r && addr_r == MODEM_CTRL_ADDR) begin
         modem_control_reg_r <= wdata_r;
      end
   end

   // interrupt line polarity follows the bus style; a floating line is masked
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_irq_pending <= 1'b0;
         o_infrared_mode <= 1'b0;
      end else begin
         if (style_r == STYLE_SEPARATE) begin
            o_irq_pending <= i_irq && modem_control_reg_r[IRQ_OE_BIT];
         end else begin
            o_irq_pending <= !i_irq;
         end
         // tells the serial side which idle level to expect on the receive line
         o_infrared_mode <= modem_control_reg_r[IR_MODE_BIT];
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);

   a_addr_stable_cs: assert property (
      (!o_chip_select_n && $past(!o_chip_select_n)) |-> $stable(o_reg_addr))
      else $error("address moved while selected");
   a_data_oe_write: assert property (
      o_data_oe |-> ((style_r == STYLE_SEPARATE) ? o_read_strobe_n : !o_write_strobe_n))
      else $error("data driven during a read");
   a_cs_frames_strobe: assert property (
      (!o_read_strobe_n || (style_r && !o_write_strobe_n)) |-> !o_chip_select_n)
      else $error("strobe without chip select");
   a_read_width: assert property (
      $fell(o_read_strobe_n) |-> (!o_read_strobe_n)[*2] ##1 o_read_strobe_n)
      else $error("read strobe width wrong");
   a_read_capture: assert property (
      (style_r && $rose(o_read_strobe_n)) |-> (o_rsp_rdata == $past(i_data)))
      else $error("read byte not taken at strobe rise");
   a_write_data_held: assert property (
      (style_r && $rose(o_write_strobe_n)) |-> (o_data_oe && $stable(o_data)))
      else $error("write data dropped at strobe rise");
   a_rd_unused_dir: assert property (
      (captured_r && !style_r) |-> o_read_strobe_n)
      else $error("read strobe moved in direction style");
   a_dir_level: assert property (
      (!style_r && !o_chip_select_n) |-> (o_write_strobe_n == !o_data_oe))
      else $error("direction line disagrees with access");
   a_dir_stable_cs: assert property (
      (!style_r && !o_chip_select_n && $past(!o_chip_select_n)) |-> $stable(o_write_strobe_n))
      else $error("direction moved while selected");
   a_rsp_bound: assert property (
      (i_cmd_valid && o_cmd_ready) |-> ##[3:40] o_rsp_valid)
      else $error("transaction did not finish");
   a_irq_dir_pol: assert property (
      (!style_r && $past(!style_r) && $past(!i_irq)) |-> o_irq_pending)
      else $error("low interrupt line not reported");

   c_sep_read: cover property (style_r && $rose(o_read_strobe_n));
   c_sep_write: cover property (style_r && $rose(o_write_strobe_n));
   c_dir_read: cover property (!style_r && $fell(o_chip_select_n) && o_write_strobe_n);
   c_dir_write: cover property (!style_r && $fell(o_chip_select_n) && !o_write_strobe_n);

endmodule : uart_host_bus_port
`default_nettype wire

// [sim/uart_device_model.sv]
// behavioural model of the uart register port on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module uart_device_model
   import uart_host_pkg::*;
(
   input wire logic i_arst_n,
   input wire logic i_bus_style,
   input wire logic [2:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_data,
   input wire logic i_irq_src,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic o_irq,
   output logic o_irq_oe,
   output logic o_tx
);
   logic [7:0] regs_r [8];
   logic sep;
   logic [7:0] modem_control_reg;
   assign sep = (i_bus_style == STYLE_SEPARATE);
   assign modem_control_reg = regs_r[MODEM_CTRL_ADDR];
   // drive the bus only while selected and reading; read strobe unused in direction style
   assign o_data_oe = !i_cs_n &&
                      (sep ? !i_rd_n : (i_wr_n == DIR_READ));
   assign o_data = regs_r[i_addr];
   // writes land on the closing edge, so data must still be valid at that moment
   always @(posedge i_wr_n or posedge i_cs_n or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < 8; k++) regs_r[k] <= 8'h00;
      end else if ((sep && !i_cs_n && i_wr_n) || (!sep && i_cs_n && !i_wr_n)) begin
         regs_r[i_addr] <= i_data;
      end
   end
   // active high gated driver, or open drain pulled low
   assign o_irq_oe = sep ? modem_control_reg[IRQ_OE_BIT] : i_irq_src;
   assign o_irq = sep ? i_irq_src : 1'b0;
   assign o_tx = modem_control_reg[IR_MODE_BIT] ? 1'b0 : 1'b1;
endmodule : uart_device_model
`default_nettype wire

// [sim/uart_host_bus_port_test.sv]
// self-checking testbench of the uart host bus controller
`timescale 1ns/1ps
`default_nettype none
module uart_host_bus_port_test;
   import uart_host_pkg::*;
   logic clk = 0, rst_n = 0, style = STYLE_SEPARATE, tog = 0, irq_src = 0;
   logic cmd_valid = 0, cmd_write = 0;
   logic [2:0] cmd_addr = 3'h0;
   logic [7:0] cmd_wdata = 8'h00, dbus, o_data, dev_q, o_rsp_rdata, rd;
   logic o_cmd_ready, o_rsp_valid, cs_n, rd_n, wr_n, o_data_oe, dev_oe, dev_irq, dev_irq_oe;
   logic irq_wire, o_irq_pending, o_infrared_mode, tx, rx_line;
   logic [2:0] reg_addr;
   int fails = 0, tests_run = 0;
   initial forever #25 clk = ~clk;
   always @(posedge clk) tog <= ~tog;
   // released lines, except the direction-style interrupt line which is pulled high, show a changing pattern so a stale value cannot pass
   assign dbus = o_data_oe ? o_data : (dev_oe ? dev_q : (8'h5a ^ {8{tog}}));
   assign irq_wire = dev_irq_oe ? dev_irq : ((style == STYLE_DIRECTION) ? 1'b1 : tog);
   assign rx_line = o_infrared_mode ? 1'b0 : 1'b1;
   uart_host_bus_port i_uart_host_bus_port (.i_clock(clk), .i_arst_n(rst_n), .i_bus_style(style),
      .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
      .i_cmd_wdata(cmd_wdata), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
      .o_rsp_rdata(o_rsp_rdata), .o_reg_addr(reg_addr), .o_chip_select_n(cs_n),
      .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .i_data(dbus), .o_data(o_data),
      .o_data_oe(o_data_oe), .i_irq(irq_wire), .o_irq_pending(o_irq_pending),
      .o_infrared_mode(o_infrared_mode));
   uart_device_model i_uart_device_model (.i_arst_n(rst_n), .i_bus_style(style),
      .i_addr(reg_addr), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(dbus),
      .i_irq_src(irq_src), .o_data(dev_q), .o_data_oe(dev_oe), .o_irq(dev_irq),
      .o_irq_oe(dev_irq_oe), .o_tx(tx));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // strobes may only move while selected; read strobe idle in direction style
   always @(negedge clk) begin
      if (rst_n && style == STYLE_SEPARATE && (!rd_n || !wr_n)) check("cs_low", cs_n, 0);
      if (rst_n && style == STYLE_DIRECTION) check("rd_idle", rd_n, 1);
   end
   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 0;
      style <= s;
      repeat (16) @(posedge clk);
      rst_n <= 1;
   endtask : do_reset
   // one command, bounded waits for take and response
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] wd);
      int n;
      logic oe_seen;
      oe_seen = 0;
      @(posedge clk);
      cmd_valid <= 1;
      cmd_write <= wr;
      cmd_addr <= a;
      cmd_wdata <= wd;
      n = 0;
      do begin @(negedge clk); n++; end while (o_cmd_ready !== 1'b1 && n < 50);
      if (n >= 50) begin fails++; conclude(); end
      @(posedge clk);
      cmd_valid <= 0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         oe_seen |= (o_data_oe === 1'b1);
      end while (o_rsp_valid !== 1'b1 && n < 50);
      if (n >= 50) begin fails++; conclude(); end
      rd = o_rsp_rdata;
      check("latency", 8'(n), 8'h05);
      check("data_oe", oe_seen, wr);
   endtask : xfer
   // every address written then read back, in the current bus style
   task automatic test_regs(input logic [7:0] seed);
      for (int a = 0; a < 8; a++) xfer(1, 3'(a), seed ^ 8'(a));
      for (int a = 0; a < 8; a++) begin
         xfer(0, 3'(a), 8'h00);
         check("rdata", rd, seed ^ 8'(a));
      end
      $display("test regs style %0d done", style);
   endtask : test_regs
   task automatic irq_expect(input logic src, input logic exp);
      @(posedge clk);
      irq_src <= src;
      repeat (3) @(negedge clk);
      check("irq_pending", o_irq_pending, exp);
   endtask : irq_expect
   // interrupt masked by the enable bit, then passed through
   task automatic test_irq_sep;
      xfer(1, MODEM_CTRL_ADDR, 8'h00);
      irq_expect(1, 0);
      xfer(1, MODEM_CTRL_ADDR, 8'h08);
      irq_expect(1, 1);
      irq_expect(0, 0);
      $display("test irq separate done");
   endtask : test_irq_sep
   // infrared mode flips the transmit idle level
   // the shadow updates one edge after done and the flag one edge later, so wait two
   task automatic test_ir_mode;
      xfer(1, MODEM_CTRL_ADDR, 8'h40);
      repeat (2) @(negedge clk);
      check("ir_flag", o_infrared_mode, 1);
      check("tx_ir", tx, 0);
      xfer(1, MODEM_CTRL_ADDR, 8'h00);
      repeat (2) @(negedge clk);
      check("ir_off", o_infrared_mode, 0);
      check("tx_std", tx, 1);
      $display("test infrared done");
   endtask : test_ir_mode
   task automatic test_irq_dir;
      irq_expect(1, 1);
      irq_expect(0, 0);
      $display("test irq direction done");
   endtask : test_irq_dir
   initial begin
      do_reset(STYLE_SEPARATE);
      check("tx_reset", tx, 1);
      test_regs(8'h3c);
      test_irq_sep();
      test_ir_mode();
      do_reset(STYLE_DIRECTION);
      test_regs(8'hc3);
      test_irq_dir();
      conclude();
   end
endmodule : uart_host_bus_port_test
`default_nettype wire
